// File: sewg_pkg.sv
// Purpose: Shared constants for the serial EEPROM write-guard device logic
// Assumes: 200 MHz system clock, serial pins sampled synchronously
// Notes: Times are kept in their own unit, cycle counts derived here
package sewg_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Opcodes, MSB first on the serial input
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // Power-up and program times in milliseconds
  localparam int unsigned POWERUP_READ_DELAY_MS = 1;
  localparam int unsigned POWERUP_WRITE_DELAY_MS = 5;
  localparam int unsigned NV_PROGRAM_TIME_MS = 10;
  // Cycles per millisecond first, so the products stay within 32 bits
  localparam int unsigned CYCLES_PER_MS = 1000000000 / CLK_PERIOD_PS;
  // Longest times round down to whole cycles
  localparam int unsigned POWERUP_READ_CYCLES =
    POWERUP_READ_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned POWERUP_WRITE_CYCLES =
    POWERUP_WRITE_DELAY_MS * CYCLES_PER_MS;
  localparam int unsigned NV_PROGRAM_CYCLES =
    NV_PROGRAM_TIME_MS * CYCLES_PER_MS;
  // Clock counts at which a write may legally end
  localparam int unsigned WRITE_END_MIN = 24;
  localparam int unsigned WRITE_END_MAX = 48;
  localparam int unsigned WRITE_END_STEP = 8;
  // Memory geometry
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned PAGE_BYTES = 4;
  // Reset values
  localparam logic LATCH_RESET = 1'b0;
endpackage

// File: sewg_timer_if.sv
// Purpose: Carrier between the core and its delay timer
// Assumes: One clock domain
// Notes: Start is a one-cycle pulse, busy and the ready flags are levels
`timescale 1ns/1ps
interface sewg_timer_if;
  logic start; // Begin a program interval
  logic busy; // Program interval running
  logic read_ready; // Power-up read delay elapsed
  logic write_ready; // Power-up write delay elapsed
  modport core (output start, input busy, read_ready, write_ready);
  modport timer (input start, output busy, read_ready, write_ready);
endinterface

// File: sewg_timer.sv
// Purpose: Power-up delays and the self-timed program interval
// Assumes: Reset stands for power being applied
// Notes: Counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module sewg_timer
  import sewg_pkg::*;
#(
  parameter int unsigned READ_CYCLES = POWERUP_READ_CYCLES,
  parameter int unsigned WRITE_CYCLES = POWERUP_WRITE_CYCLES,
  parameter int unsigned PROG_CYCLES = NV_PROGRAM_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core side
  sewg_timer_if.timer tif
);
  logic [31:0] pu_cnt; // Cycles since power-up, saturating
  logic [31:0] prog_cnt; // Cycles left in the program interval
  // Power-up counter stops once the longer delay has passed
  always_ff @(posedge clk) begin
    if (rst) begin
      pu_cnt <= 32'h0;
    end else if (pu_cnt < WRITE_CYCLES) begin
      pu_cnt <= pu_cnt + 32'h1;
    end
  end
  // Ready flags: reads within 1 ms, writes within 5 ms
  always_ff @(posedge clk) begin
    if (rst) begin
      tif.read_ready <= 1'b0;
      tif.write_ready <= 1'b0;
    end else begin
      tif.read_ready <= (pu_cnt >= READ_CYCLES);
      tif.write_ready <= (pu_cnt >= WRITE_CYCLES);
    end
  end
  // Program interval, never longer than the program time
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_cnt <= 32'h0;
    end else if (tif.start) begin
      prog_cnt <= PROG_CYCLES;
    end else if (prog_cnt != 32'h0) begin
      prog_cnt <= prog_cnt - 32'h1;
    end
  end
  assign tif.busy = (prog_cnt != 32'h0);
endmodule // sewg_timer

// File: sewg_core.sv
// Purpose: Serial EEPROM device logic with write-arm latch and guards
// Assumes: Serial pins synchronous to SYS_CLK, RST models power-up
// Notes: Serial clock edges are found by sampling against SYS_CLK
// Operation
// - Power up idle, no instruction until selected
// - Select falling edge, or select low as reset ends, needed before first command
// - Serial output high impedance at power-up
// - Write-arm latch cleared at power-up
// - Latch set only by set command; guards writes
// - Program starts only at permitted deselect counts
// - Write-guard low clears the write-arm latch
// - Program cycle ends within 10 ms
// - Pause low floats output; high drives again
// - Eight-bit MSB-first opcodes, four commands
// - Clear command and program end clear latch
// - Write ends after clock 24, 32, 40, 48
`timescale 1ns/1ps
module sewg_core
  import sewg_pkg::*;
#(
  parameter int unsigned READ_CYCLES = POWERUP_READ_CYCLES,
  parameter int unsigned WRITE_CYCLES = POWERUP_WRITE_CYCLES,
  parameter int unsigned PROG_CYCLES = NV_PROGRAM_CYCLES
) (
  // System
  input wire logic SYS_CLK,
  input wire logic RST,
  // Serial bus
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // Guard and pause pins
  input wire logic WGUARD_N,
  input wire logic PAUSE_N,
  // Status
  output logic PROG_BUSY,
  output logic WRITE_LATCH
);
  typedef enum logic [2:0] {
    ST_STANDBY, ST_OPCODE, ST_ADDR, ST_WDATA, ST_RDATA, ST_IGNORE
  } sewg_state_e;

  sewg_timer_if tif ();
  sewg_timer #(
    .READ_CYCLES(READ_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk(SYS_CLK),
    .rst(RST),
    .tif(tif)
  );

  logic [7:0] mem [MEM_DEPTH]; // Nonvolatile array
  logic [7:0] page_buf [PAGE_BYTES]; // Staged page data
  logic [PAGE_BYTES-1:0] page_valid; // Staged byte flags
  sewg_state_e state; // Transaction state
  logic sclk_q; // Last serial clock sample
  logic sel_q; // Last select sample
  logic seen_fall; // Select has fallen since power-up
  logic [7:0] shreg; // Incoming shift register
  logic [5:0] clk_cnt; // Serial clocks in this transaction
  logic [2:0] bit_cnt; // Bit within current byte
  logic [7:0] addr; // Byte address
  logic [7:0] prog_addr; // Page base for programming
  logic [7:0] rd_byte; // Byte being shifted out
  logic is_write; // Transaction is a write
  logic wr_abort; // Write spoiled by guard pin
  logic start_prog; // One-cycle program start
  logic busy_q; // Delayed busy for end detect

  // Edge decode, serial clock edges held still during a pause
  wire run = PAUSE_N;
  wire sclk_rise = run & SCLK & ~sclk_q;
  wire sclk_fall = run & ~SCLK & sclk_q;
  wire sel_fall = sel_q & ~SEL_N;
  wire sel_rise = ~sel_q & SEL_N;
  wire [7:0] next_shreg = {shreg[6:0], SDI};
  wire byte_done = sclk_rise & (bit_cnt == 3'h7);
  wire [5:0] next_clk_cnt = clk_cnt + 6'h1;
  // Deselect at 24..48 in steps of 8 counts as a valid write end
  wire legal_end = (clk_cnt >= 6'(WRITE_END_MIN)) &&
    (clk_cnt <= 6'(WRITE_END_MAX)) && (clk_cnt[2:0] == 3'h0);
  wire write_ok = is_write & ~wr_abort & WRITE_LATCH & tif.write_ready &
    ~tif.busy;
  wire prog_end = busy_q & ~tif.busy;
  wire [1:0] pslot = addr[1:0];
  // No staging while programming, so a late frame cannot spoil the page
  wire stage_byte = (state == ST_WDATA) & byte_done & ~SEL_N &
    ~tif.busy;
  wire stage_clear = sel_fall & ~tif.busy;
  // Page base is taken only when a program cycle really starts
  wire prog_go = sel_rise & write_ok & legal_end;

  assign tif.start = start_prog;

  // Sample history for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sclk_q <= 1'b0;
      sel_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      sclk_q <= run ? SCLK : sclk_q;
      sel_q <= SEL_N;
      busy_q <= tif.busy;
    end
  end

  // First select fall arms the command decoder
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      seen_fall <= 1'b0;
    end else if (sel_fall) begin
      seen_fall <= 1'b1;
    end
  end

  // Transaction state machine
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= ST_STANDBY;
      clk_cnt <= 6'h0;
      bit_cnt <= 3'h0;
      shreg <= 8'h0;
      addr <= 8'h0;
      is_write <= 1'b0;
      rd_byte <= 8'h0;
    end else if (SEL_N) begin
      state <= ST_STANDBY;
      clk_cnt <= 6'h0;
      bit_cnt <= 3'h0;
      is_write <= 1'b0;
    end else if (sel_fall && seen_fall == 1'b0) begin
      state <= ST_OPCODE;
    end else if (sel_fall || state == ST_STANDBY) begin
      state <= seen_fall ? ST_OPCODE : ST_STANDBY;
      clk_cnt <= 6'h0;
      bit_cnt <= 3'h0;
    end else if (sclk_rise) begin
      shreg <= next_shreg;
      bit_cnt <= bit_cnt + 3'h1;
      // Count saturates; any count past 48 is illegal anyway
      clk_cnt <= (clk_cnt == 6'h3F) ? clk_cnt : next_clk_cnt;
      if (byte_done) begin
        case (state)
          ST_OPCODE: begin
            // Reads wait for the power-up read delay
            if (next_shreg == OP_READ && tif.read_ready) begin
              state <= ST_ADDR;
            end else if (next_shreg == OP_WRITE) begin
              state <= ST_ADDR;
              is_write <= 1'b1;
            end else begin
              state <= ST_IGNORE;
            end
          end
          ST_ADDR: begin
            addr <= next_shreg;
            rd_byte <= mem[next_shreg];
            state <= is_write ? ST_WDATA : ST_RDATA;
          end
          ST_WDATA: begin
            // Page wraps within four bytes
            addr <= {addr[7:2], pslot + 2'h1};
          end
          ST_RDATA: begin
            addr <= addr + 8'h1;
            rd_byte <= mem[addr + 8'h1];
          end
          default: begin
            state <= ST_IGNORE;
          end
        endcase
      end
    end
  end

  // Staged page data, committed only by the program cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST || stage_clear) begin
      page_valid <= '0;
    end else if (stage_byte) begin
      page_buf[pslot] <= next_shreg;
      page_valid[pslot] <= 1'b1;
    end
  end

  // Write spoiled if the guard drops while selected; set beats clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_abort <= 1'b0;
    end else if (!SEL_N && !WGUARD_N) begin
      wr_abort <= 1'b1;
    end else if (sel_fall) begin
      wr_abort <= 1'b0;
    end
  end

  // Program start on a legal deselect only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      start_prog <= 1'b0;
      prog_addr <= 8'h0;
    end else begin
      start_prog <= prog_go;
      if (prog_go) begin
        prog_addr <= {addr[7:2], 2'h0};
      end
    end
  end

  // Program array once the interval completes
  always_ff @(posedge SYS_CLK) begin
    if (prog_end) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_valid[i]) begin
          mem[{prog_addr[7:2], 2'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Write-arm latch: set command only, many ways to clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      WRITE_LATCH <= LATCH_RESET;
    end else if (!WGUARD_N) begin
      WRITE_LATCH <= 1'b0;
    end else if (prog_end || tif.busy) begin
      WRITE_LATCH <= 1'b0;
    end else if (sel_rise && state == ST_IGNORE && clk_cnt == 6'h8) begin
      // Command counts only if select rises right after bit eight
      if (shreg == OP_SET_WRITE_LATCH) begin
        WRITE_LATCH <= 1'b1;
      end else if (shreg == OP_CLEAR_WRITE_LATCH) begin
        WRITE_LATCH <= 1'b0;
      end
    end
  end

  // Serial output, driven only in a read and not paused
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SDO <= 1'b0;
      SDO_OE <= 1'b0;
      PROG_BUSY <= 1'b0;
    end else begin
      PROG_BUSY <= tif.busy;
      SDO_OE <= !SEL_N && PAUSE_N && state == ST_RDATA;
      if (sclk_fall && state == ST_RDATA) begin
        SDO <= rd_byte[3'h7 - bit_cnt];
      end
    end
  end
endmodule // sewg_core

// File: sewg_monitor.sv
// Purpose: Port checks for the write-guard device
// Assumes: One clock, RST synchronous active high
// Notes: Program length is measured by a counter
`timescale 1ns/1ps
module sewg_monitor #(
  parameter int unsigned PROG_CYCLES = 100
) (
  // System
  input wire logic SYS_CLK,
  input wire logic RST,
  // Serial bus
  input wire logic SEL_N,
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic SDO,
  input wire logic SDO_OE,
  // Guard, pause, status
  input wire logic WGUARD_N,
  input wire logic PAUSE_N,
  input wire logic PROG_BUSY,
  input wire logic WRITE_LATCH
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [31:0] busy_len; // Busy cycles so far
  // Count the busy run, cleared when idle
  always_ff @(posedge SYS_CLK) begin
    if (RST || !PROG_BUSY) busy_len <= '0;
    else busy_len <= busy_len + 32'h1;
  end
  a_reset_quiet: assert property (disable iff (1'b0) RST |=>
    !SDO_OE && !PROG_BUSY && !WRITE_LATCH) else $error("reset state");
  a_guard_clears: assert property (!WGUARD_N |=> !WRITE_LATCH)
    else $error("guard left latch set");
  a_deselect_float: assert property (SEL_N [*3] |-> !SDO_OE)
    else $error("output driven while deselected");
  a_pause_float: assert property (!PAUSE_N [*3] |-> !SDO_OE)
    else $error("output driven in pause");
  a_busy_latch_low: assert property (
    PROG_BUSY && $past(PROG_BUSY) |-> !WRITE_LATCH)
    else $error("latch set while busy");
  a_busy_deselect: assert property ($rose(PROG_BUSY) |->
    $past(SEL_N, 1) && $past(SEL_N, 2)) else $error("busy w/o deselect");
  a_busy_armed: assert property ($rose(PROG_BUSY) |->
    $past(WRITE_LATCH, 3)) else $error("program without latch");
  a_prog_length: assert property ($fell(PROG_BUSY) |->
    busy_len == PROG_CYCLES) else $error("program length wrong");
  a_latch_cause: assert property ($rose(WRITE_LATCH) |->
    $past(SEL_N) && $past(WGUARD_N)) else $error("latch set oddly");
endmodule // sewg_monitor

// File: sewg_host.sv
// Purpose: Host serial controller model
// Assumes: Pins move 1 ns after a SYS_CLK rising edge
// Notes: Serial clock stands low between frames
`timescale 1ns/1ps
module sewg_host #(
  parameter int HALF = 4
) (
  // System clock
  input wire logic clk,
  // Serial bus
  output logic sel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic last; // Last bit seen on the data line
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    last = 1'b0;
  end
  // Select falls before the first bit
  task automatic open_frame();
    @(posedge clk) #1 sel_n = 1'b0;
    repeat (HALF) @(posedge clk);
    #1;
  endtask
  // One byte each way, MSB first
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      repeat (HALF) @(posedge clk);
      // A floating line reads as the inverse of the last bit
      last = sdo_oe ? sdo : ~last;
      q[i] = last;
      #1 sclk = 1'b1;
      repeat (HALF) @(posedge clk);
      #1 sclk = 1'b0;
    end
  endtask
  // Deselect after whole bytes only, count chosen by caller
  task automatic close_frame();
    repeat (HALF) @(posedge clk);
    #1 sel_n = 1'b1;
    sdi = ~sdi;
    repeat (2 * HALF) @(posedge clk);
    #1;
  endtask
endmodule // sewg_host

// File: sewg_tb_top.sv
// Purpose: Self-checking bench for the write-guard device
// Assumes: Shortened delays, 5 ns clock
// Notes: Host model drives the serial pins
`timescale 1ns/1ps
module sewg_tb_top;
  import sewg_pkg::*;
  localparam int unsigned PG = 400; // Short program time
  logic SYS_CLK, RST, SEL_N, SCLK, SDI, SDO, SDO_OE;
  logic WGUARD_N, PAUSE_N, PROG_BUSY, WRITE_LATCH;
  int failures, total_checks;
  logic [7:0] q; // Byte read back
  sewg_core #(.READ_CYCLES(100), .WRITE_CYCLES(600), .PROG_CYCLES(PG)) DUT (
    .SYS_CLK(SYS_CLK), .RST(RST), .SEL_N(SEL_N), .SCLK(SCLK), .SDI(SDI),
    .SDO(SDO), .SDO_OE(SDO_OE), .WGUARD_N(WGUARD_N), .PAUSE_N(PAUSE_N),
    .PROG_BUSY(PROG_BUSY), .WRITE_LATCH(WRITE_LATCH));
  sewg_host host (.clk(SYS_CLK), .sel_n(SEL_N), .sclk(SCLK), .sdi(SDI),
    .sdo(SDO), .sdo_oe(SDO_OE));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  // Bounded wait for a busy level
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (PROG_BUSY !== v && n < lim) begin
      cycles(1);
      n++;
    end
    chk(PROG_BUSY, v);
    if (PROG_BUSY !== v) print_verdict();
  endtask
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.xfer(op, q);
    host.close_frame();
  endtask
  task automatic t_latch();
    cmd(OP_SET_WRITE_LATCH);
    chk(WRITE_LATCH, 1'b1);
    cmd(OP_CLEAR_WRITE_LATCH);
    chk(WRITE_LATCH, 1'b0);
    cmd(OP_SET_WRITE_LATCH);
    WGUARD_N = 1'b0;
    cycles(3);
    chk(WRITE_LATCH, 1'b0);
    WGUARD_N = 1'b1;
    $display("test latch done");
  endtask
  // Write with a bad ending, no arm or a guard drop must not program
  task automatic t_refused(input logic arm, input int nbytes,
    input logic guard);
    if (arm) cmd(OP_SET_WRITE_LATCH);
    host.open_frame();
    host.xfer(OP_WRITE, q);
    if (guard) WGUARD_N = 1'b0;
    for (int k = 1; k < nbytes; k++) host.xfer(8'h55, q);
    WGUARD_N = 1'b1;
    host.close_frame();
    cycles(5);
    chk(PROG_BUSY, 1'b0);
    $display("test refused done");
  endtask
  // Read and write before the power-up delays have passed
  task automatic t_early();
    host.open_frame();
    host.xfer(OP_READ, q);
    host.xfer(8'h00, q);
    host.xfer(8'h00, q);
    chk(SDO_OE, 1'b0);
    host.close_frame();
    t_refused(1'b1, 3, 1'b0);
    cmd(OP_CLEAR_WRITE_LATCH);
    chk(WRITE_LATCH, 1'b0);
    $display("test early done");
  endtask
  // Page write of n bytes, then read back
  task automatic t_page(input int n);
    logic [7:0] base;
    base = 8'(4 * n);
    cmd(OP_SET_WRITE_LATCH);
    host.open_frame();
    host.xfer(OP_WRITE, q);
    host.xfer(base, q);
    for (int k = 0; k < n; k++) host.xfer(8'(16 * n + k) ^ 8'h5A, q);
    host.close_frame();
    wait_busy(1'b1, 10);
    chk(WRITE_LATCH, 1'b0);
    cmd(OP_SET_WRITE_LATCH);
    chk(WRITE_LATCH, 1'b0);
    // A write while programming must neither start nor spoil the page
    host.open_frame();
    host.xfer(OP_WRITE, q);
    host.xfer(base, q);
    host.xfer(8'hFF, q);
    host.close_frame();
    chk(PROG_BUSY, 1'b1);
    wait_busy(1'b0, PG + 20);
    chk(WRITE_LATCH, 1'b0);
    host.open_frame();
    host.xfer(OP_READ, q);
    host.xfer(base, q);
    for (int k = 0; k < n; k++) begin
      host.xfer(8'h00, q);
      chk(q, 8'(16 * n + k) ^ 8'h5A);
      if (k == 0) begin
        PAUSE_N = 1'b0;
        cycles(6);
        chk(SDO_OE, 1'b0);
        PAUSE_N = 1'b1;
        cycles(6);
        chk(SDO_OE, 1'b1);
      end
    end
    host.close_frame();
    chk(SDO_OE, 1'b0);
    $display("test page %0d done", n);
  endtask
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    RST = 1'b1;
    WGUARD_N = 1'b1;
    PAUSE_N = 1'b1;
    failures = 0;
    total_checks = 0;
    cycles(2);
    RST = 1'b0;
    chk({SDO_OE, PROG_BUSY, WRITE_LATCH}, 8'h00);
    t_early();
    cycles(100);
    t_refused(1'b0, 3, 1'b0);
    t_latch();
    t_refused(1'b1, 2, 1'b0);
    t_refused(1'b1, 3, 1'b1);
    for (int n = 1; n <= 4; n++) t_page(n);
    print_verdict();
  end
endmodule // sewg_tb_top
bind sewg_core sewg_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (
  .SYS_CLK(SYS_CLK), .RST(RST), .SEL_N(SEL_N), .SCLK(SCLK), .SDI(SDI),
  .SDO(SDO), .SDO_OE(SDO_OE), .WGUARD_N(WGUARD_N), .PAUSE_N(PAUSE_N),
  .PROG_BUSY(PROG_BUSY), .WRITE_LATCH(WRITE_LATCH));
